/* File: panel_mux_map.svh */
/*
  Reset values and fixed constants of the panel timing output stage.
  Assumes inclusion by panel_mux_pkg.sv and the design modules only.
*/
// Behaviour
// [RULE_01] Sync pin carries horizontal or composite sync, per select bit, on pixel clock.
// [RULE_02] Sync polarity bit 0 gives active low sync pin, 1 gives active high.
// [RULE_03] Vertical sync pin follows pixel clock with the same sync polarity bit.
// [RULE_04] Blank pin marks blanking on pixel clock; its complement is display enable. Code drives it low in blanking, so the pin is the enable.
// [RULE_05] Pixel clock comes from crystal, PLL (direct or divided) or external input.
// [RULE_06] Pixel clock output may be inverted right before the pin.
// [RULE_07] Horizontal start is active high with its bit 0, active low with 1.
// [RULE_08] Vertical start is active high with its bit 0, active low with 1.
// [RULE_09] Horizontal load is active high with its bit 0, active low with 1.
// [RULE_10] Strap high routes panel timing signals onto the shared pins.
// [RULE_11] Panel mode: vertical clock, vertical start, polarity toggle on sync/blank/vsync pins.
// [RULE_12] Conventional mode: start, load, enable pins carry PLL controls two, three, one.
// [RULE_13] System fixes the strap level during power-on reset and never changes it.
// [RULE_14] Strap is sampled once at reset release and held until next reset.
`ifndef PANEL_MUX_MAP_SVH
`define PANEL_MUX_MAP_SVH
`define PIN_IDLE_RESET 1'b1
`define PIXEL_CLOCK_RESET 1'b0
`define PANEL_MODE_RESET 1'b0
`define DIV_COUNT_RESET 4'h0
`define DIV_RATIO_W 4
`endif

/* File: panel_mux_pkg.sv */
/*
  Types shared by the panel timing output stage.
  Assumes panel_mux_map.svh is present in the same folder.
*/
`include "panel_mux_map.svh"
package panel_mux_pkg;
  typedef enum logic [2:0]
  {
    SRC_CRYSTAL = 3'h1,
    SRC_PLL = 3'h2,
    SRC_EXTERNAL = 3'h4
  } clock_source_type;

  typedef enum logic [1:0]
  {
    STRAP_WAIT = 2'h1,
    STRAP_HELD = 2'h2
  } strap_state_type;

  typedef struct packed
  {
    logic composite_sync_select;
    logic sync_polarity_invert;
    logic hstart_polarity_invert;
    logic vstart_polarity_invert;
    logic hload_polarity_invert;
    clock_source_type clock_source;
    logic clock_divide;
    logic [`DIV_RATIO_W-1:0] divide_ratio;
    logic pixel_clock_invert;
  } output_config_type;

  typedef struct packed
  {
    logic hsync;
    logic csync;
    logic vsync;
    logic blank;
    logic vertical_clock;
    logic horizontal_start;
    logic vertical_start;
    logic horizontal_load;
    logic vertical_output_enable;
    logic polarity_toggle;
  } timing_type;

  typedef struct packed
  {
    logic pll_control_one;
    logic pll_control_two;
    logic pll_control_three;
  } pll_control_type;
endpackage

/* File: pixel_clock_divider.sv */
/*
  Divides a sampled clock level by counting its rising edges.
  Assumes the source level is already synchronous to clk_sys.
*/
`timescale 1ns/100ps
`include "panel_mux_map.svh"
module pixel_clock_divider
  import panel_mux_pkg::*;
#(
  parameter int RATIO_W = `DIV_RATIO_W
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic source_level,
  input wire logic divide,
  input wire logic [RATIO_W-1:0] ratio,
  output logic clock_level
);
  logic prev_r;
  logic half_r;
  logic [RATIO_W-1:0] count_r;
  logic rise;

  assign rise = source_level & ~prev_r;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      prev_r <= `PIXEL_CLOCK_RESET;
    else
      prev_r <= source_level;
  end

  // A ratio of zero is treated as one so the divided clock never stops.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_r <= RATIO_W'(`DIV_COUNT_RESET);
      half_r <= `PIXEL_CLOCK_RESET;
    end
    else if (rise)
    begin
      if (count_r + RATIO_W'(1) >= ratio)
      begin
        count_r <= `DIV_COUNT_RESET;
        half_r <= ~half_r;
      end
      else
        count_r <= count_r + RATIO_W'(1);
    end
  end

  assign clock_level = divide ? half_r : source_level; // [RULE_05]
endmodule

/* File: panel_timing_output_mux.sv */
/*
  Output stage of the monitor interface: pin function multiplexing,
  signal polarity and pixel clock source selection.
  Assumes all inputs, clock levels included, are synchronous to clk_sys
  and that the strap is stable while reset_n is low.
*/
`timescale 1ns/100ps
`include "panel_mux_map.svh"
module panel_timing_output_mux
  import panel_mux_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic panel_timing_select,
  input wire output_config_type cfg,
  input wire timing_type timing,
  input wire pll_control_type pll_ctl,
  input wire logic crystal_clock_in,
  input wire logic pll_clock_in,
  input wire logic external_pixel_clock_in,
  output logic horiz_composite_sync,
  output logic vsync_pin,
  output logic blank_pin,
  output logic hstart_pin,
  output logic hload_pin,
  output logic vout_enable_pin,
  output logic pixel_clock_out,
  output logic panel_mode
);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic drive_level(input logic active, input logic active_low);
    drive_level = active_low ? ~active : active;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  strap_state_type strap_state_r;
  logic panel_mode_r;

  // Sampled one cycle after release, never under the asynchronous reset.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strap_state_r <= STRAP_WAIT;
      panel_mode_r <= `PANEL_MODE_RESET;
    end
    else
    begin
      unique case (strap_state_r)
        STRAP_WAIT:
        begin
          panel_mode_r <= panel_timing_select; // [RULE_14]
          strap_state_r <= STRAP_HELD;
        end
        STRAP_HELD:
          panel_mode_r <= panel_mode_r; // [RULE_14]
        default:
          strap_state_r <= STRAP_WAIT;
      endcase
    end
  end

  assign panel_mode = panel_mode_r;

  ////////////////////////////////////////////////////////////////////////
  logic source_level;
  logic divide_en;
  logic clock_level;
  logic level_prev_r;
  logic pixel_en;

  always_comb
  begin
    source_level = external_pixel_clock_in;
    divide_en = 1'b0;
    unique case (cfg.clock_source)
      SRC_CRYSTAL:
      begin
        source_level = crystal_clock_in; // [RULE_05]
        divide_en = cfg.clock_divide;
      end
      SRC_PLL:
      begin
        source_level = pll_clock_in; // [RULE_05]
        divide_en = cfg.clock_divide;
      end
      SRC_EXTERNAL:
        source_level = external_pixel_clock_in; // [RULE_05]
      default:
        source_level = external_pixel_clock_in;
    endcase
  end

  pixel_clock_divider #(
    .RATIO_W(`DIV_RATIO_W)
  ) pixel_clock_divider_i (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .source_level(source_level),
    .divide(divide_en),
    .ratio(cfg.divide_ratio),
    .clock_level(clock_level)
  );

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      level_prev_r <= `PIXEL_CLOCK_RESET;
    else
      level_prev_r <= clock_level;
  end

  // Pixel outputs change on the rising edge of the internal pixel clock.
  assign pixel_en = clock_level & ~level_prev_r;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      pixel_clock_out <= `PIXEL_CLOCK_RESET;
    else
      pixel_clock_out <= clock_level ^ cfg.pixel_clock_invert; // [RULE_06]
  end

  ////////////////////////////////////////////////////////////////////////
  logic sync_sel;
  logic sync_low;

  assign sync_sel = cfg.composite_sync_select ? timing.csync : timing.hsync; // [RULE_01]
  assign sync_low = ~cfg.sync_polarity_invert; // [RULE_02]

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      horiz_composite_sync <= `PIN_IDLE_RESET;
      vsync_pin <= `PIN_IDLE_RESET;
      blank_pin <= `PIN_IDLE_RESET;
    end
    else if (pixel_en)
    begin
      if (panel_mode_r)
      begin
        horiz_composite_sync <= timing.vertical_clock; // [RULE_11]
        vsync_pin <= timing.polarity_toggle; // [RULE_11]
        blank_pin <= drive_level(timing.vertical_start, cfg.vstart_polarity_invert); // [RULE_08]
      end
      else
      begin
        horiz_composite_sync <= drive_level(sync_sel, sync_low); // [RULE_01]
        vsync_pin <= drive_level(timing.vsync, sync_low); // [RULE_03]
        // Low during blanking, so the pin doubles as a display enable.
        blank_pin <= ~timing.blank; // [RULE_04]
      end
    end
  end

  // PLL controls are not pixel timed and follow every system cycle.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hstart_pin <= `PIN_IDLE_RESET;
      hload_pin <= `PIN_IDLE_RESET;
      vout_enable_pin <= `PIN_IDLE_RESET;
    end
    else if (!panel_mode_r)
    begin
      hstart_pin <= pll_ctl.pll_control_two; // [RULE_12]
      hload_pin <= pll_ctl.pll_control_three; // [RULE_12]
      vout_enable_pin <= pll_ctl.pll_control_one; // [RULE_12]
    end
    else if (pixel_en)
    begin
      hstart_pin <= drive_level(timing.horizontal_start, cfg.hstart_polarity_invert); // [RULE_07]
      hload_pin <= drive_level(timing.horizontal_load, cfg.hload_polarity_invert); // [RULE_09]
      vout_enable_pin <= timing.vertical_output_enable; // [RULE_10]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // Each check except the two strap checks first asks that the previous edge was out of reset,
  // since the pins are still held at their reset level on the first edge after release.
  a_sync_select: assert property ($past(reset_n) && // [RULE_01]
    $past(pixel_en) && !panel_mode_r && $past(!panel_mode_r) |->
    horiz_composite_sync == ($past(sync_sel) ^ ~$past(cfg.sync_polarity_invert)))
    else $error("sync pin does not follow selected sync");
  a_sync_polarity: assert property ($past(reset_n) && // [RULE_02]
    $past(pixel_en) && $past(!panel_mode_r) && $past(cfg.sync_polarity_invert) |->
    horiz_composite_sync == $past(sync_sel))
    else $error("sync pin not active high when inverted");
  a_vsync_level: assert property ($past(reset_n) && // [RULE_03]
    $past(pixel_en) && $past(!panel_mode_r) |->
    vsync_pin == ($past(timing.vsync) ^ ~$past(cfg.sync_polarity_invert)))
    else $error("vertical sync level wrong");
  a_blank_level: assert property ($past(reset_n) && // [RULE_04]
    $past(pixel_en) && $past(!panel_mode_r) |->
    blank_pin == !$past(timing.blank))
    else $error("blank pin wrong");
  a_pixel_invert: assert property ($past(reset_n) |-> // [RULE_06]
    pixel_clock_out == ($past(clock_level) ^ $past(cfg.pixel_clock_invert)))
    else $error("pixel clock inversion wrong");
  a_ext_direct: assert property ($past(reset_n) && // [RULE_05]
    $past(cfg.clock_source) == SRC_EXTERNAL && $past(!cfg.pixel_clock_invert) |->
    pixel_clock_out == $past(external_pixel_clock_in))
    else $error("external clock not passed through");
  a_hstart_level: assert property ($past(reset_n) && // [RULE_07]
    $past(pixel_en) && $past(panel_mode_r) |->
    hstart_pin == ($past(timing.horizontal_start) ^ $past(cfg.hstart_polarity_invert)))
    else $error("horizontal start level wrong");
  a_vstart_level: assert property ($past(reset_n) && // [RULE_08]
    $past(pixel_en) && $past(panel_mode_r) |->
    blank_pin == ($past(timing.vertical_start) ^ $past(cfg.vstart_polarity_invert)))
    else $error("vertical start level wrong");
  a_hload_level: assert property ($past(reset_n) && // [RULE_09]
    $past(pixel_en) && $past(panel_mode_r) |->
    hload_pin == ($past(timing.horizontal_load) ^ $past(cfg.hload_polarity_invert)))
    else $error("horizontal load level wrong");
  a_panel_pins: assert property ($past(reset_n) && // [RULE_11]
    $past(pixel_en) && $past(panel_mode_r) |->
    horiz_composite_sync == $past(timing.vertical_clock) && vsync_pin == $past(timing.polarity_toggle))
    else $error("panel signals not on shared pins");
  a_pll_pins: assert property ($past(reset_n) && // [RULE_12]
    $past(!panel_mode_r) |->
    hstart_pin == $past(pll_ctl.pll_control_two) && vout_enable_pin == $past(pll_ctl.pll_control_one))
    else $error("pll controls not on shared pins");
  a_strap_held: assert property (strap_state_r == STRAP_HELD && // [RULE_14]
    $past(strap_state_r) == STRAP_HELD |->
    $stable(panel_mode_r))
    else $error("panel mode changed after strap sampling");
  a_strap_taken: assert property (strap_state_r == STRAP_WAIT |=> // [RULE_14]
    panel_mode_r == $past(panel_timing_select) && strap_state_r == STRAP_HELD)
    else $error("strap not captured at release");

  c_panel_mode: cover property (panel_mode_r && pixel_en);
  c_composite: cover property (!panel_mode_r && pixel_en && cfg.composite_sync_select);
  c_divided_pll: cover property (cfg.clock_source == SRC_PLL && cfg.clock_divide && pixel_en);
  c_inverted: cover property (cfg.pixel_clock_invert && $rose(clock_level));
endmodule

/* File: lcd_panel_model.sv */
/*
  Panel side of the output stage: latches the six shared pins on each
  rising pixel clock, as a TFT panel or digital RGB monitor would.
  Assumes the pins arrive as one vector ordered sync, vsync, blank,
  hstart, hload, output enable.
*/
`timescale 1ns/100ps
module lcd_panel_model
(
  input wire logic pixel_clock_out,
  input wire logic [5:0] pins,
  output logic [5:0] seen_r,
  output logic display_enable
);
  ////////////////////////////////////////////////////////////////////////////
  // A real panel sees nothing between clock edges, so neither does this one.
  always @(posedge pixel_clock_out)
    seen_r <= pins;

  // In conventional mode the blank pin is high outside blanking, which is what a panel takes as enable.
  assign display_enable = seen_r[3];
endmodule

/* File: panel_timing_output_mux_bench.sv */
/*
  Self-checking bench for the panel timing output stage.
  Assumes the design files and lcd_panel_model.sv are compiled first.
*/
`timescale 1ns/100ps
module panel_timing_output_mux_bench;
  import panel_mux_pkg::*;
  logic clk_sys, reset_n, strap, xtal, pll, ext;
  output_config_type cfg;
  timing_type tm;
  pll_control_type pctl;
  logic hcs, vs, bl, hst, hld, voe, pclk, pmode, de;
  logic [5:0] seen;
  int err_count, num_checks, cyc;

  panel_timing_output_mux panel_timing_output_mux_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .panel_timing_select(strap), .cfg(cfg), .timing(tm), .pll_ctl(pctl), .crystal_clock_in(xtal),
    .pll_clock_in(pll), .external_pixel_clock_in(ext), .horiz_composite_sync(hcs), .vsync_pin(vs),
    .blank_pin(bl), .hstart_pin(hst), .hload_pin(hld), .vout_enable_pin(voe), .pixel_clock_out(pclk),
    .panel_mode(pmode));
  lcd_panel_model lcd_panel_model_i (.pixel_clock_out(pclk), .pins({hcs, vs, bl, hst, hld, voe}),
    .seen_r(seen), .display_enable(de));

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Source clocks stay well below half the system rate, as the sampler needs.
  always @(negedge clk_sys)
  begin
    cyc <= cyc + 1;
    xtal <= cyc[1];
    pll <= cyc[2];
    ext <= ~cyc[3];
    if (cyc == 5000)
    begin
      err_count++;
      complete_run();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (err_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask

  task automatic do_reset(input logic s);
    @(negedge clk_sys);
    reset_n = 1'b0;
    strap = s;
    cfg.clock_source = SRC_CRYSTAL;
    cfg.clock_divide = 1'b0;
    cfg.pixel_clock_invert = 1'b0;
    repeat (10) @(negedge clk_sys);
    chk("reset levels", 8'hFC, {hcs, vs, bl, hst, hld, voe, pclk, pmode});
    reset_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("panel mode", {7'h00, s}, {7'h00, pmode});
  endtask

  // Every pattern moves each polarity bit and each source signal, so a swapped pin shows.
  task automatic mode_pins(input logic panel);
    logic [5:0] exp;
    for (int i = 0; i < 16; i++)
    begin
      @(negedge clk_sys);
      cfg.composite_sync_select = i[0];
      cfg.sync_polarity_invert = i[1];
      cfg.hstart_polarity_invert = i[0];
      cfg.vstart_polarity_invert = i[2];
      cfg.hload_polarity_invert = i[3];
      tm = timing_type'({i[2], i[3], i[2] ^ i[3], i[3], i[0], i[1] ^ i[2], i[3], ~i[2], i[0] ^ i[3], ~i[1]});
      pctl = pll_control_type'({i[1], i[2], i[3]});
      if (panel)
        exp = {i[0], ~i[1], i[3] ^ i[2], i[0] ^ i[1] ^ i[2], ~i[2] ^ i[3], i[0] ^ i[3]};
      else
        exp = {~((i[0] ? i[3] : i[2]) ^ i[1]), ~(i[2] ^ i[3] ^ i[1]), ~i[3], i[2], i[3], i[1]};
      repeat (24) @(negedge clk_sys);
      chk(panel ? "panel pins" : "conventional pins", {2'h0, exp}, {2'h0, seen});
      // In panel mode the blank pin carries vertical start, so the enable the panel sees follows it.
      chk("display enable", {7'h00, panel ? tm.vertical_start ^ cfg.vstart_polarity_invert : ~tm.blank},
        {7'h00, de});
    end
  endtask

  task automatic clock_direct();
    clock_source_type srcs[3] = '{SRC_CRYSTAL, SRC_PLL, SRC_EXTERNAL};
    logic lvl;
    for (int s = 0; s < 6; s++)
    begin
      @(negedge clk_sys);
      cfg.clock_source = srcs[s / 2];
      cfg.pixel_clock_invert = s[0];
      cfg.clock_divide = 1'b0;
      repeat (2) @(negedge clk_sys);
      for (int k = 0; k < 16; k++)
      begin
        @(posedge clk_sys);
        lvl = (s < 2) ? xtal : ((s < 4) ? pll : ext);
        @(negedge clk_sys);
        chk("pixel clock", {7'h00, lvl ^ s[0]}, {7'h00, pclk});
      end
    end
  endtask

  // Edges are counted, not phases, so one edge of slack covers the window start.
  task automatic clock_divided(input clock_source_type src, input logic [3:0] ratio, input int rises);
    logic last;
    int n;
    @(negedge clk_sys);
    cfg.clock_source = src;
    cfg.clock_divide = 1'b1;
    cfg.divide_ratio = ratio;
    repeat (40) @(negedge clk_sys);
    n = 0;
    last = pclk;
    repeat (96)
    begin
      @(negedge clk_sys);
      if (pclk === 1'b1 && last === 1'b0)
        n++;
      last = pclk;
    end
    num_checks++;
    if (n < rises - 1 || n > rises + 1)
    begin
      $display("Error divided clock rises expected %0d seen %0d", rises, n);
      err_count++;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset_n = 1'b0;
    strap = 1'b0;
    cyc = 0;
    xtal = 1'b0;
    pll = 1'b0;
    ext = 1'b0;
    err_count = 0;
    num_checks = 0;
    cfg = '0;
    cfg.clock_source = SRC_CRYSTAL;
    tm = '0;
    pctl = '0;
    do_reset(1'b0);
    mode_pins(1'b0);
    clock_direct();
    clock_divided(SRC_CRYSTAL, 4'h1, 12);
    clock_divided(SRC_CRYSTAL, 4'h2, 6);
    clock_divided(SRC_PLL, 4'h1, 6);
    clock_divided(SRC_EXTERNAL, 4'h2, 6);
    do_reset(1'b1);
    mode_pins(1'b1);
    @(negedge clk_sys);
    strap = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk("held strap", 8'h01, {7'h00, pmode});
    do_reset(1'b0);
    complete_run();
  end
endmodule
